// File: logic/scss_regs.svh
// register offsets, field positions, reset values and counts of the clock source switch
`ifndef SCSS_REGS_SVH
`define SCSS_REGS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define SCSS_CTRL_OFS        12'h000
`define SCSS_STATUS_OFS      12'h004
`define SCSS_CTRL_RESET      10'h000
`define SCSS_CTRL_MASK       32'h0000_03FF

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define SCSS_F_EXT_SEL       0
`define SCSS_F_MAIN_DIS      1
`define SCSS_F_CPU_LO        2
`define SCSS_F_CPU_HI        4
`define SCSS_F_SLEEP_LO      5
`define SCSS_F_SLEEP_HI      6
`define SCSS_F_SLOW_OFF      7
`define SCSS_F_DEEP_SLEEP    8
`define SCSS_F_CRYSTAL_ON    9

// ---------------------------------------------------------------
// timing and counts
// ---------------------------------------------------------------
`define SCSS_MAIN_OSC_MHZ    12
`define SCSS_DIV_ONE         3'h0
`define SCSS_DIV_R0          9'h001
`define SCSS_DIV_R1          9'h002
`define SCSS_DIV_R2          9'h004
`define SCSS_DIV_R3          9'h008
`define SCSS_DIV_R4          9'h010
`define SCSS_DIV_R5          9'h020
`define SCSS_DIV_R6          9'h080
`define SCSS_DIV_R7          9'h100
`define SCSS_SLEEP_N0        16'h0040
`define SCSS_SLEEP_N1        16'h0200
`define SCSS_SLEEP_N2        16'h1000
`define SCSS_SLEEP_N3        16'h8000

`endif

// File: logic/scss_pkg.sv
// types and shared functions of the clock source switch
`include "scss_regs.svh"

package scss_pkg;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } scss_apb_req_type;

  typedef struct packed {
    logic       crystal_on;
    logic       deep_sleep;
    logic       slow_off;
    logic [1:0] sleep_sel;
    logic [2:0] cpu_speed;
    logic       main_osc_disable;
    logic       ext_clock_select;
  } scss_ctrl_type;

  typedef enum logic [2:0] {
    SW_RUN       = 3'b000,
    SW_WAIT_FALL = 3'b001,
    SW_SYNC1     = 3'b010,
    SW_SYNC2     = 3'b011,
    SW_WAIT_NEG  = 3'b100
  } scss_sw_state_type;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  function automatic logic [8:0] scss_div_ratio(input logic [2:0] code);
    logic [8:0] r;
    r = `SCSS_DIV_R0;
    unique case (code)
      3'h0: r = `SCSS_DIV_R0;
      3'h1: r = `SCSS_DIV_R1;
      3'h2: r = `SCSS_DIV_R2;
      3'h3: r = `SCSS_DIV_R3;
      3'h4: r = `SCSS_DIV_R4;
      3'h5: r = `SCSS_DIV_R5;
      3'h6: r = `SCSS_DIV_R6;
      3'h7: r = `SCSS_DIV_R7;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] scss_sleep_count(input logic [1:0] sel);
    logic [15:0] n;
    n = `SCSS_SLEEP_N0;
    unique case (sel)
      2'h0: n = `SCSS_SLEEP_N0;
      2'h1: n = `SCSS_SLEEP_N1;
      2'h2: n = `SCSS_SLEEP_N2;
      2'h3: n = `SCSS_SLEEP_N3;
    endcase
    return n;
  endfunction

endpackage

// File: logic/scss_sync.sv
// two-stage level synchroniser, one per bit
`timescale 1ns/1ns
`default_nettype none

module scss_sync #(
  parameter int W = 11
) (
  input  wire logic         ref_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_r;
  logic [W-1:0] sync_nxt;

  // first stage feeds only the second
  always_comb begin
    meta_nxt = async_i;
    sync_nxt = meta_r;
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;

endmodule // scss_sync

`default_nettype wire

// File: logic/scss_clkdiv.sv
// processor clock divider counting edges of the base clock net
`timescale 1ns/1ns
`default_nettype none

module scss_clkdiv (
  input  wire logic       ref_clk_i,
  input  wire logic       reset_i,
  input  wire logic       base_i,
  input  wire logic [2:0] cpu_speed_i,
  output logic            proc_clk_o
);
  import scss_pkg::*;

  logic       prev_r;
  logic       prev_nxt;
  logic [8:0] cnt_r;
  logic [8:0] cnt_nxt;
  logic       pclk_r;
  logic       pclk_nxt;
  logic [8:0] ratio;

  // half a processor period spans `ratio` base half-cycles
  always_comb begin
    ratio    = scss_div_ratio(cpu_speed_i);
    prev_nxt = base_i;
    cnt_nxt  = cnt_r;
    pclk_nxt = pclk_r;
    if (base_i != prev_r) begin
      if (cnt_r + 9'h001 >= ratio) begin
        cnt_nxt  = 9'h000;
        pclk_nxt = ~pclk_r;
      end else begin
        cnt_nxt = cnt_r + 9'h001;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prev_r <= 1'b0;
      cnt_r  <= 9'h000;
      pclk_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      cnt_r  <= cnt_nxt;
      pclk_r <= pclk_nxt;
    end
  end

  assign proc_clk_o = pclk_r;

endmodule // scss_clkdiv

`default_nettype wire

// File: logic/scss_top.sv
// clock source switch: glitch-free base net select, processor divider, sleep timer, apb regs
//
// Behaviour
// - base net follows main oscillator or external clock per current source selection.
// - processor clock divides base net by one of eight ratios.
// - main oscillator nominally 12 MHz and default base net source.
// - four sleep intervals from 1.95 ms to 1 second.
// - every function runs from, or is resynchronised to, the base net; here sleep timer and slow clock run from the slow oscillator.
// - async inputs and slow oscillator are double-synchronised before use.
// - slow oscillator clocks sleep timer, also output as clock.
// - slow oscillator may be turned off in deep sleep or with crystal running.
// - external select resets to 0, so boot is always from main oscillator.
// - select set makes external input the base net source.
// - source may change anytime; changeover shows no disturbance.
// - divider two or more: select takes effect after base rising edge.
// - old clock disabled after next base falling edge, giving full cycle setup.
// - new source enable passes two stages clocked by that new source.
// - after synchronisation, gating starts at next falling edge of new source.
// - divide-by-one: select takes effect on falling edge, disable at once.
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "scss_regs.svh"

module scss_top (
  input  wire logic                       ref_clk_i,
  input  wire logic                       reset_i,
  input  wire scss_pkg::scss_apb_req_type apb_req_i,
  output logic                            pready_o,
  output logic [31:0]                     prdata_o,
  output logic                            pslverr_o,
  input  wire logic                       main_osc_clk_i,
  input  wire logic                       ext_clk_i,
  input  wire logic                       slow_osc_clk_i,
  input  wire logic [7:0]                 async_in_i,
  output logic                            base_clock_o,
  output logic                            processor_clock_o,
  output logic                            slow_clock_o,
  output logic                            main_osc_en_o,
  output logic                            slow_osc_en_o,
  output logic                            sleep_tick_o,
  output logic [7:0]                      async_sync_o
);
  import scss_pkg::*;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [10:0] sync_w;
  logic        main_s;
  logic        ext_s;
  logic        slow_s;

  scss_sync #(
    .W (11)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .async_i   ({async_in_i, slow_osc_clk_i, ext_clk_i, main_osc_clk_i}),
    .sync_o    (sync_w)
  );

  assign main_s = sync_w[0];
  assign ext_s  = sync_w[1];
  assign slow_s = sync_w[2];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  scss_ctrl_type     ctrl_r;
  scss_ctrl_type     ctrl_nxt;
  scss_sw_state_type state_r;
  scss_sw_state_type state_nxt;
  logic              sel_eff_r;
  logic              sel_eff_nxt;
  logic              cur_src_r;
  logic              cur_src_nxt;
  logic              gate_on_r;
  logic              gate_on_nxt;
  logic              base_r;
  logic              base_nxt;
  logic              base_prev_r;
  logic              base_prev_nxt;
  logic [2:0]        src_prev_r;
  logic [2:0]        src_prev_nxt;
  logic              pready_r;
  logic              pready_nxt;
  logic [31:0]       prdata_r;
  logic [31:0]       prdata_nxt;
  logic              pslverr_r;
  logic              pslverr_nxt;
  logic [15:0]       sleep_cnt_r;
  logic [15:0]       sleep_cnt_nxt;
  logic              sleep_tick_r;
  logic              sleep_tick_nxt;
  logic              slow_clk_r;
  logic              slow_clk_nxt;
  logic              main_en_r;
  logic              main_en_nxt;
  logic              slow_en_r;
  logic              slow_en_nxt;
  logic [7:0]        async_r;
  logic [7:0]        async_nxt;

  // ---------------------------------------------------------------
  // apb slave
  // ---------------------------------------------------------------
  logic        acc;
  logic        wr_fire;
  logic        hit_ctrl;
  logic        hit_stat;
  logic [31:0] status_w;

  // one wait state keeps read data and answer flops simple
  always_comb begin
    acc         = apb_req_i.psel & apb_req_i.penable;
    wr_fire     = acc & pready_r & apb_req_i.pwrite;
    hit_ctrl    = apb_req_i.paddr == `SCSS_CTRL_OFS;
    hit_stat    = apb_req_i.paddr == `SCSS_STATUS_OFS;
    status_w    = {25'h000_0000, state_r, gate_on_r, cur_src_r, sel_eff_r, base_r};
    pready_nxt  = acc & ~pready_r;
    prdata_nxt  = 32'h0000_0000;
    pslverr_nxt = 1'b0;
    ctrl_nxt    = ctrl_r;
    if (acc & ~pready_r) begin
      pslverr_nxt = ~(hit_ctrl | hit_stat);
      if (!apb_req_i.pwrite) begin
        if (hit_ctrl) begin
          prdata_nxt = {22'h00_0000, ctrl_r};
        end else if (hit_stat) begin
          prdata_nxt = status_w;
        end
      end
    end
    // reserved bits dropped on write, read back as zero
    if (wr_fire && hit_ctrl) begin
      ctrl_nxt = scss_ctrl_type'(apb_req_i.pwdata[9:0]);
    end
  end

  // ---------------------------------------------------------------
  // source switch
  // ---------------------------------------------------------------
  logic div_one;
  logic base_rise;
  logic base_fall;
  logic main_fall;
  logic ext_rise;
  logic ext_fall;
  logic main_rise;
  logic cur_fall;
  logic new_rise;
  logic new_fall;

  always_comb begin
    div_one   = ctrl_r.cpu_speed == `SCSS_DIV_ONE;
    base_rise = base_r & ~base_prev_r;
    base_fall = ~base_r & base_prev_r;
    main_rise = main_s & ~src_prev_r[0];
    main_fall = ~main_s & src_prev_r[0];
    ext_rise  = ext_s & ~src_prev_r[1];
    ext_fall  = ~ext_s & src_prev_r[1];
    cur_fall  = cur_src_r ? ext_fall : main_fall;
    new_rise  = sel_eff_r ? ext_rise : main_rise;
    new_fall  = sel_eff_r ? ext_fall : main_fall;

    src_prev_nxt  = {slow_s, ext_s, main_s};
    base_prev_nxt = base_r;
    sel_eff_nxt   = sel_eff_r;
    state_nxt     = state_r;
    cur_src_nxt   = cur_src_r;
    gate_on_nxt   = gate_on_r;

    // select bit only lands while no handover is in flight
    if (state_r == SW_RUN) begin
      if (div_one ? base_fall : base_rise) begin
        sel_eff_nxt = ctrl_r.ext_clock_select;
      end
    end

    unique case (state_r)
      SW_RUN: begin
        if (sel_eff_r != cur_src_r) begin
          if (div_one && !base_r) begin
            gate_on_nxt = 1'b0;
            state_nxt   = SW_SYNC1;
          end else begin
            state_nxt = SW_WAIT_FALL;
          end
        end
      end
      SW_WAIT_FALL: begin
        if (cur_fall) begin
          gate_on_nxt = 1'b0;
          state_nxt   = SW_SYNC1;
        end
      end
      SW_SYNC1: begin
        if (new_rise) begin
          state_nxt = SW_SYNC2;
        end
      end
      SW_SYNC2: begin
        if (new_rise) begin
          state_nxt = SW_WAIT_NEG;
        end
      end
      SW_WAIT_NEG: begin
        if (new_fall) begin
          cur_src_nxt = sel_eff_r;
          gate_on_nxt = 1'b1;
          state_nxt   = SW_RUN;
        end
      end
      default: begin
        state_nxt   = SW_RUN;
        gate_on_nxt = 1'b0;
      end
    endcase

    // parked low between sources, so no runt pulse
    if (gate_on_nxt) begin
      base_nxt = cur_src_nxt ? ext_s : main_s;
    end else begin
      base_nxt = 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // slow clock, sleep timer, enables
  // ---------------------------------------------------------------
  logic        slow_rise;
  logic [15:0] sleep_lim;

  always_comb begin
    slow_rise      = slow_s & ~src_prev_r[2];
    sleep_lim      = scss_sleep_count(ctrl_r.sleep_sel);
    slow_clk_nxt   = slow_s;
    sleep_cnt_nxt  = sleep_cnt_r;
    sleep_tick_nxt = 1'b0;
    if (slow_rise) begin
      if (sleep_cnt_r + 16'h0001 >= sleep_lim) begin
        sleep_cnt_nxt  = 16'h0000;
        sleep_tick_nxt = 1'b1;
      end else begin
        sleep_cnt_nxt = sleep_cnt_r + 16'h0001;
      end
    end
    // slow oscillator may stop only in deep sleep or with crystal up
    slow_en_nxt = ~(ctrl_r.slow_off & (ctrl_r.deep_sleep | ctrl_r.crystal_on));
    main_en_nxt = ~ctrl_r.main_osc_disable;
    async_nxt   = sync_w[10:3];
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_r       <= scss_ctrl_type'(`SCSS_CTRL_RESET);
      state_r      <= SW_RUN;
      sel_eff_r    <= 1'b0;
      cur_src_r    <= 1'b0;
      gate_on_r    <= 1'b1;
      base_r       <= 1'b0;
      base_prev_r  <= 1'b0;
      src_prev_r   <= 3'h0;
      pready_r     <= 1'b0;
      prdata_r     <= 32'h0000_0000;
      pslverr_r    <= 1'b0;
      sleep_cnt_r  <= 16'h0000;
      sleep_tick_r <= 1'b0;
      slow_clk_r   <= 1'b0;
      main_en_r    <= 1'b1;
      slow_en_r    <= 1'b1;
      async_r      <= 8'h00;
    end else begin
      ctrl_r       <= ctrl_nxt;
      state_r      <= state_nxt;
      sel_eff_r    <= sel_eff_nxt;
      cur_src_r    <= cur_src_nxt;
      gate_on_r    <= gate_on_nxt;
      base_r       <= base_nxt;
      base_prev_r  <= base_prev_nxt;
      src_prev_r   <= src_prev_nxt;
      pready_r     <= pready_nxt;
      prdata_r     <= prdata_nxt;
      pslverr_r    <= pslverr_nxt;
      sleep_cnt_r  <= sleep_cnt_nxt;
      sleep_tick_r <= sleep_tick_nxt;
      slow_clk_r   <= slow_clk_nxt;
      main_en_r    <= main_en_nxt;
      slow_en_r    <= slow_en_nxt;
      async_r      <= async_nxt;
    end
  end

  // ---------------------------------------------------------------
  // processor clock
  // ---------------------------------------------------------------
  scss_clkdiv u_div (
    .ref_clk_i   (ref_clk_i),
    .reset_i     (reset_i),
    .base_i      (base_r),
    .cpu_speed_i (ctrl_r.cpu_speed),
    .proc_clk_o  (processor_clock_o)
  );

  assign pready_o      = pready_r;
  assign prdata_o      = prdata_r;
  assign pslverr_o     = pslverr_r;
  assign base_clock_o  = base_r;
  assign slow_clock_o  = slow_clk_r;
  assign main_osc_en_o = main_en_r;
  assign slow_osc_en_o = slow_en_r;
  assign sleep_tick_o  = sleep_tick_r;
  assign async_sync_o  = async_r;

endmodule // scss_top

`default_nettype wire

// File: testbench/scss_top_checker.sv
// assertion checker bound to the clock source switch top
`timescale 1ns/1ns
`default_nettype none
module scss_top_checker (
  input wire logic                       ref_clk_i,
  input wire logic                       reset_i,
  input wire scss_pkg::scss_apb_req_type apb_req_i,
  input wire logic                       pready_o,
  input wire logic [31:0]                prdata_o,
  input wire logic                       pslverr_o,
  input wire logic                       slow_osc_clk_i,
  input wire logic [7:0]                 async_in_i,
  input wire logic                       base_clock_o,
  input wire logic                       processor_clock_o,
  input wire logic                       slow_clock_o,
  input wire logic                       main_osc_en_o,
  input wire logic                       sleep_tick_o,
  input wire logic [7:0]                 async_sync_o
);
  import scss_pkg::*;
  // shortest half period the bench main and external sources make
  localparam int MIN_HALF = 8;
  logic        b_last, p_last, b_arm, p_arm, wr_ctrl;
  logic [15:0] b_run, p_run;
  assign wr_ctrl = pready_o & apb_req_i.psel & apb_req_i.pwrite & (apb_req_i.paddr == 12'h000);
  // first runs after reset may be cut short, so arm on the first fall
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      b_arm <= 1'b0;
      p_arm <= 1'b0;
    end else begin
      b_arm <= b_arm | (b_last & ~base_clock_o);
      p_arm <= p_arm | (p_last & ~processor_clock_o);
    end
    b_last <= base_clock_o;
    p_last <= processor_clock_o;
    b_run  <= (base_clock_o != b_last) ? 16'h0001 : b_run + 16'h0001;
    p_run  <= (processor_clock_o != p_last) ? 16'h0001 : p_run + 16'h0001;
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_access;
    apb_req_i.psel && apb_req_i.penable && !pready_o;
  endsequence
  sequence s_ctrl_write;
    $past(wr_ctrl) || $past(wr_ctrl, 2);
  endsequence
  a_boot_main: assert property ($fell(reset_i) |-> main_osc_en_o && !base_clock_o)
    else $error("not at boot state");
  a_pready_wait: assert property (s_access |=> pready_o)
    else $error("no ready after one wait");
  a_pready_pulse: assert property (pready_o |=> !pready_o)
    else $error("ready too long");
  a_prdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data outside ready");
  a_slverr_map: assert property (pready_o |-> pslverr_o == !(apb_req_i.paddr inside {12'h000, 12'h004}))
    else $error("wrong error response");
  a_osc_en_cause: assert property ($changed(main_osc_en_o) |-> s_ctrl_write)
    else $error("oscillator enable moved alone");
  a_async_sync: assert property ($stable(async_in_i)[*4] |-> async_sync_o == async_in_i)
    else $error("async input not passed");
  a_slow_follow: assert property ($rose(slow_osc_clk_i) |-> ##[1:4] $rose(slow_clock_o))
    else $error("slow clock not followed");
  a_tick_pulse: assert property (sleep_tick_o |=> !sleep_tick_o)
    else $error("sleep tick too long");
  a_base_no_runt: assert property (b_arm && base_clock_o != b_last |-> b_run >= MIN_HALF)
    else $error("short pulse on base clock");
  a_proc_no_runt: assert property (p_arm && processor_clock_o != p_last |-> p_run >= MIN_HALF)
    else $error("short pulse on processor clock");
endmodule // scss_top_checker
bind scss_top scss_top_checker chk_u (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .apb_req_i(apb_req_i), .pready_o(pready_o),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o), .slow_osc_clk_i(slow_osc_clk_i),
  .async_in_i(async_in_i), .base_clock_o(base_clock_o), .processor_clock_o(processor_clock_o),
  .slow_clock_o(slow_clock_o), .main_osc_en_o(main_osc_en_o), .sleep_tick_o(sleep_tick_o),
  .async_sync_o(async_sync_o)
);
`default_nettype wire

// File: testbench/scss_src_model.sv
// behavioural model of the oscillators feeding the clock source switch
`timescale 1ns/1ns
`default_nettype none
module scss_src_model #(
  parameter int MAIN_HALF = 10,
  parameter int EXT_HALF  = 8, // 15 MHz on main's 12 MHz scale, inside 1 to 24
  parameter int SLOW_HALF = 2,
  parameter int STARTUP   = 100
) (
  input  wire logic ref_clk_i,
  input  wire logic main_en_i,
  input  wire logic slow_en_i,
  output logic      main_clk_o,
  output logic      ext_clk_o,
  output logic      slow_clk_o
);
  logic m_q   = 1'b0;
  logic e_q   = 1'b0;
  logic s_q   = 1'b0;
  int   m_cnt = 0;
  int   e_cnt = 0;
  int   s_cnt = 0;
  int   warm  = STARTUP;
  assign main_clk_o = m_q;
  assign ext_clk_o  = e_q;
  assign slow_clk_o = s_q;
  // halves stretched far below spec: the switch oversamples at the bench clock
  always @(posedge ref_clk_i) begin
    warm <= !main_en_i ? 0 : (warm < STARTUP ? warm + 1 : warm);
    // a stopped oscillator ends its high half, then rests low
    if (m_q || (main_en_i && warm == STARTUP)) begin
      m_cnt <= (m_cnt == MAIN_HALF - 1) ? 0 : m_cnt + 1;
      if (m_cnt == MAIN_HALF - 1) m_q <= !m_q;
    end
    // external source runs free with full digital swings
    e_cnt <= (e_cnt == EXT_HALF - 1) ? 0 : e_cnt + 1;
    if (e_cnt == EXT_HALF - 1) e_q <= !e_q;
    if (s_q || slow_en_i) begin
      s_cnt <= (s_cnt == SLOW_HALF - 1) ? 0 : s_cnt + 1;
      if (s_cnt == SLOW_HALF - 1) s_q <= !s_q;
    end
  end
endmodule // scss_src_model
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench for the clock source switch
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import scss_pkg::*;
  logic             ref_clk_i;
  logic             reset_i;
  scss_apb_req_type req;
  logic             pready, pslverr, err, main_clk, ext_clk, slow_clk, slow_q;
  logic             base, proc, main_en, slow_en, tick;
  logic [31:0]      prdata, rd, v;
  logic [7:0]       async_in, async_out;
  logic [11:0]      a;
  int               n_errors, samples_checked, n, i;
  int               seed = 32'he218;
  scss_top dut_u (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .apb_req_i(req), .pready_o(pready),
    .prdata_o(prdata), .pslverr_o(pslverr), .main_osc_clk_i(main_clk), .ext_clk_i(ext_clk),
    .slow_osc_clk_i(slow_clk), .async_in_i(async_in), .base_clock_o(base),
    .processor_clock_o(proc), .slow_clock_o(slow_q), .main_osc_en_o(main_en),
    .slow_osc_en_o(slow_en), .sleep_tick_o(tick), .async_sync_o(async_out)
  );
  scss_src_model src_u (
    .ref_clk_i(ref_clk_i), .main_en_i(main_en), .slow_en_i(slow_en),
    .main_clk_o(main_clk), .ext_clk_o(ext_clk), .slow_clk_o(slow_clk)
  );
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  task automatic end_sim();
    if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic timeout();
    n_errors++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    end_sim();
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    int t;
    @(posedge ref_clk_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: ad, pwdata: wd};
    @(posedge ref_clk_i);
    req.penable <= 1'b1;
    for (t = 0; t < 20; t++) begin
      @(posedge ref_clk_i);
      if (pready === 1'b1) break;
    end
    if (t == 20) timeout();
    rd = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  function automatic logic sig(input int w);
    return w == 0 ? base : (w == 1 ? proc : tick);
  endfunction
  // n counts the edges until the watched signal shows the level
  task automatic wait_lvl(input int w, input logic lv);
    for (n = 0; n < 40000 && sig(w) !== lv; n++) @(posedge ref_clk_i);
    if (n == 40000) timeout();
  endtask
  task automatic high_run(input int w);
    wait_lvl(w, 1'b0);
    wait_lvl(w, 1'b1);
    wait_lvl(w, 1'b0);
  endtask
  function automatic int ratio(input int c);
    int r[8] = '{1, 2, 4, 8, 16, 32, 128, 256};
    return r[c];
  endfunction
  // return path clears the disable first and waits out the warm-up
  task automatic switch_src(input logic ext, input logic [2:0] spd);
    int k;
    apb(1'b1, 12'h000, {27'h0, spd, 2'b01});
    if (ext) begin
      // next instruction lands only once the select is taken, else a stopped main hangs it
      for (k = 0; k < 50; k++) begin
        apb(1'b0, 12'h004, 32'h0000_0000);
        if (rd[1] === 1'b1) break;
      end
      if (k == 50) timeout();
      apb(1'b1, 12'h000, {27'h0, spd, 2'b11});
    end else begin
      repeat (200) @(posedge ref_clk_i);
      apb(1'b1, 12'h000, {27'h0, spd, 2'b00});
    end
    for (k = 0; k < 50; k++) begin
      apb(1'b0, 12'h004, 32'h0000_0000);
      if (rd[6:4] === 3'h0 && rd[2] === ext) break;
    end
    if (k == 50) timeout();
    chk(32'(rd[3:1]), 32'({1'b1, ext, ext}));
    chk(32'(main_en), 32'(!ext));
    high_run(0);
    chk(n, ext ? 8 : 10);
    high_run(1);
    chk(n, (ext ? 8 : 10) * ratio(spd));
  endtask
  initial begin
    reset_i = 1'b1;
    req = '0;
    async_in = 8'h00;
    n_errors = 0;
    samples_checked = 0;
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    apb(1'b0, 12'h000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h004, 32'h0000_0000);
    chk(32'(rd[6:1]), 32'h0000_0004);
    apb(1'b1, 12'h004, 32'hFFFF_FFFF);
    chk(32'(err), 32'h0000_0000);
    a = 12'(($random(seed) & 32'h0000_0FF8) | 32'h0000_0008);
    apb(1'b1, a, $random(seed));
    apb(1'b0, a, 32'h0000_0000);
    chk({rd[30:0], err}, 32'h0000_0001);
    for (i = 0; i < 5; i++) begin
      // reserved bits always written as zero
      v = (i == 0) ? 32'h0000_0180 : ($random(seed) & 32'h0000_03FE);
      apb(1'b1, 12'h000, v);
      apb(1'b0, 12'h000, 32'h0000_0000);
      chk(rd, v);
      chk(32'({main_en, slow_en}), 32'({~v[1], ~(v[7] & (v[8] | v[9]))}));
    end
    apb(1'b1, 12'h000, 32'h0000_0000);
    repeat (200) @(posedge ref_clk_i);
    for (i = 0; i < 8; i++) begin
      apb(1'b1, 12'h000, 32'(i << 2));
      high_run(1);
      chk(n, 10 * ratio(i));
    end
    for (i = 0; i < 3; i++) begin
      apb(1'b1, 12'h000, 32'(i << 5));
      wait_lvl(2, 1'b1);
      @(posedge ref_clk_i);
      wait_lvl(2, 1'b1);
      @(posedge ref_clk_i);
      wait_lvl(2, 1'b1);
      chk(n + 1, 4 * (64 << (3 * i)));
    end
    for (i = 0; i < 8; i++) begin
      async_in <= 8'($random(seed));
      repeat (5) @(posedge ref_clk_i);
      chk(32'(async_out), 32'(async_in));
    end
    switch_src(1'b1, 3'h1);
    switch_src(1'b0, 3'h1);
    switch_src(1'b1, 3'h0);
    switch_src(1'b0, 3'h0);
    end_sim();
  end
endmodule // testbench
`default_nettype wire
